// ---- rtl/sfr_read_front.v ----
// sfr_read_front.v: serial flash read front end (fast, dual out, dual io, quad io reads)
// assumes the spi clock is far slower than clock; memory array sits outside, read combinationally
// spi clock at most clock/8: every pin edge costs three clocks of synchroniser latency
// write busy and quad peripheral mode come from logic on this clock, so no synchroniser
`timescale 1ns/1ns
`default_nettype none
`include "sfr_defines.vh"
module sfr_read_front #(
    parameter AW = `SFR_ADDR_BITS // address width
) (
    input wire clock, // system clock
    input wire rst, // synchronous reset, active high
    input wire spiClk, // serial clock pin
    input wire chipSelN, // chip select pin, active low
    input wire [3:0] dataLineIn, // data lines 0..3 as seen at the pins
    input wire writeBusy, // program, erase or status write cycle running
    input wire quadPeripheralMode, // quad peripheral mode enabled
    input wire [7:0] memData, // memory byte at memAddr
    output reg [AW-1:0] memAddr, // current read address
    output reg [3:0] dataLineOut, // data lines 0..3 driven value
    output reg [3:0] dataLineOe, // data lines 0..3 output enable
    output reg enhancedMode, // continuous enhanced mode active
    output reg pinFuncSuspend // protect and hold functions suspended
);
    // address length cut to the phase counter's width on purpose
    localparam [31:0] AW_FULL = AW;
    localparam [5:0] AW_BITS = AW_FULL[5:0];

    // frame phases
    localparam ST_IDLE = 3'd0;
    localparam ST_OPC = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_MODE = 3'd3;
    localparam ST_DUMMY = 3'd4;
    localparam ST_DATA = 3'd5;
    localparam ST_IGNORE = 3'd6;

    // width codes: bits moved per clock
    localparam W1 = 2'd0;
    localparam W2 = 2'd1;
    localparam W4 = 2'd2;

    function [2:0] bitsPer;
        input [1:0] w;
        begin
            case (w)
                W2: bitsPer = 3'd2;
                W4: bitsPer = 3'd4;
                default: bitsPer = 3'd1;
            endcase
        end
    endfunction

    // performance-enhance mode byte: upper nibble the inverse of the lower
    function keepsEnh;
        input [7:0] m;
        begin
            keepsEnh = (m[7:4] == ~m[3:0]);
        end
    endfunction

    // opcode dummy length; a quad-lane fast, dual out or dual io opcode takes the six-clock form
    function [5:0] dummyFor;
        input [1:0] w;
        input [5:0] dflt;
        begin
            if (w == W4)
                dummyFor = 6'd`SFR_QUAD_DUMMY_CLKS;
            else
                dummyFor = dflt;
        end
    endfunction

    reg [2:0] sclkSync_ff;
    reg [1:0] csSync_ff;
    reg [3:0] dinSync1_ff;
    reg [3:0] dinSync2_ff;
    reg csPrev_ff;

    // frame state; cleared by reset, most of it rebuilt at each frame start
    reg [2:0] state_ff;
    reg [1:0] inW_ff;
    reg [1:0] outW_ff;
    reg [5:0] cnt_ff;
    reg [7:0] opc_ff;
    reg [AW-1:0] addrSh_ff;
    reg [7:0] modeSh_ff;
    reg useMode_ff;
    reg keepEnh_ff;
    reg [5:0] dummyLen_ff;
    reg [7:0] outSh_ff;
    reg [3:0] outBit_ff;
    reg frameFf_ff;

    // two-stage synchronisers on every pin; edges are taken from the second stage onward
    always @(posedge clock) begin
        if (rst) begin
            sclkSync_ff <= 3'b000;
            csSync_ff <= 2'b11;
            csPrev_ff <= 1'b1;
        end else begin
            sclkSync_ff <= {sclkSync_ff[1:0], spiClk};
            csSync_ff <= {csSync_ff[0], chipSelN};
            csPrev_ff <= csSync_ff[1];
        end
    end

    // data line synchronisers, one pair of flops per lane
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : dinSync
            always @(posedge clock) begin
                if (rst) begin
                    dinSync1_ff[lane] <= 1'b0;
                    dinSync2_ff[lane] <= 1'b0;
                end else begin
                    dinSync1_ff[lane] <= dataLineIn[lane];
                    dinSync2_ff[lane] <= dinSync1_ff[lane];
                end
            end
        end
    endgenerate

    // edge strobes last one clock each
    wire csN = csSync_ff[1];
    wire sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2];
    wire sclkFall = ~sclkSync_ff[1] & sclkSync_ff[2];
    wire csFall = csPrev_ff & ~csN;
    wire csRise = ~csPrev_ff & csN;
    wire [2:0] inBits = bitsPer(inW_ff);
    wire [2:0] outBits = bitsPer(outW_ff);
    // shift-in views for each lane width; unused lanes are don't-care
    wire [7:0] opcNext = (inW_ff == W4) ? {opc_ff[3:0], dinSync2_ff} : {opc_ff[6:0], dinSync2_ff[0]};
    wire [AW-1:0] addrNext = (inW_ff == W4) ? {addrSh_ff[AW-5:0], dinSync2_ff} :
                             (inW_ff == W2) ? {addrSh_ff[AW-3:0], dinSync2_ff[1:0]} :
                             {addrSh_ff[AW-2:0], dinSync2_ff[0]};
    wire [7:0] modeNext = {modeSh_ff[3:0], dinSync2_ff};

    // frame sequencer: bits taken on synchronised rising edges, data launched on falling ones;
    // deselect wins over any edge seen in the same clock
    always @(posedge clock) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            inW_ff <= W1;
            outW_ff <= W1;
            cnt_ff <= 6'd0;
            opc_ff <= 8'h00;
            addrSh_ff <= {AW{1'b0}};
            modeSh_ff <= 8'h00;
            useMode_ff <= 1'b0;
            keepEnh_ff <= 1'b0;
            dummyLen_ff <= 6'd0;
            outSh_ff <= 8'h00;
            outBit_ff <= 4'd0;
            frameFf_ff <= 1'b0;
            memAddr <= {AW{1'b0}};
            dataLineOut <= 4'h0;
            dataLineOe <= 4'h0;
            enhancedMode <= 1'b0;
            pinFuncSuspend <= 1'b0;
        end else if (csN) begin
            // deselect ends any read and releases every line
            dataLineOe <= 4'h0;
            dataLineOut <= 4'h0;
            pinFuncSuspend <= 1'b0;
            state_ff <= ST_IDLE;
            // enhanced mode is entered at the mode byte, but left only once per frame, on the way out
            if (csRise) begin
                if (useMode_ff && !keepEnh_ff)
                    enhancedMode <= 1'b0;
                if (frameFf_ff && cnt_ff == 6'd8 && state_ff == ST_OPC)
                    enhancedMode <= 1'b0;
            end
        end else begin
            // frame start: lane widths are fixed before the first rising edge
            if (csFall) begin
                cnt_ff <= 6'd0;
                frameFf_ff <= 1'b0;
                opc_ff <= 8'h00;
                if (enhancedMode && writeBusy) begin
                    // no opcode to refuse, so the whole frame is dropped
                    state_ff <= ST_IGNORE;
                    useMode_ff <= 1'b0;
                end else if (enhancedMode) begin
                    // opcode skipped; straight into quad address
                    state_ff <= ST_ADDR;
                    inW_ff <= W4;
                    outW_ff <= W4;
                    useMode_ff <= 1'b1;
                    keepEnh_ff <= 1'b0;
                    pinFuncSuspend <= 1'b1;
                end else begin
                    state_ff <= ST_OPC;
                    inW_ff <= quadPeripheralMode ? W4 : W1;
                    outW_ff <= W1;
                    useMode_ff <= 1'b0;
                    // quad-lane framing takes the protect and hold pins as well
                    pinFuncSuspend <= quadPeripheralMode;
                end
            end else if (sclkRise) begin
                case (state_ff)
                    ST_OPC: begin
                        // opcode counted in bits so one-lane and four-lane opcodes share the path
                        opc_ff <= opcNext;
                        cnt_ff <= cnt_ff + {3'd0, inBits};
                        if (cnt_ff + {3'd0, inBits} == 6'd8) begin
                            frameFf_ff <= (opcNext == `SFR_OP_RESET_ENH);
                            cnt_ff <= 6'd8;
                            if (writeBusy) begin
                                state_ff <= ST_IGNORE;
                            end else begin
                                state_ff <= ST_ADDR;
                                cnt_ff <= 6'd0;
                                case (opcNext)
                                    `SFR_OP_FAST: begin
                                        outW_ff <= inW_ff;
                                        dummyLen_ff <= dummyFor(inW_ff, 6'd`SFR_FAST_DUMMY_CLKS);
                                    end
                                    `SFR_OP_DUAL_OUT: begin
                                        outW_ff <= (inW_ff == W4) ? W4 : W2;
                                        dummyLen_ff <= dummyFor(inW_ff, 6'd`SFR_DUAL_OUT_DUMMY_CLKS);
                                    end
                                    `SFR_OP_DUAL_IO: begin
                                        inW_ff <= (inW_ff == W4) ? W4 : W2;
                                        outW_ff <= (inW_ff == W4) ? W4 : W2;
                                        dummyLen_ff <= dummyFor(inW_ff, 6'd`SFR_DUAL_IO_DUMMY_CLKS);
                                    end
                                    `SFR_OP_QUAD_IO: begin
                                        inW_ff <= W4;
                                        outW_ff <= W4;
                                        useMode_ff <= 1'b1;
                                        keepEnh_ff <= 1'b0;
                                        pinFuncSuspend <= 1'b1;
                                    end
                                    // opcodes outside the four reads are refused quietly
                                    default: state_ff <= ST_IGNORE;
                                endcase
                                // a lone FFh frame is parked here until deselect
                                if (opcNext == `SFR_OP_RESET_ENH) begin
                                    state_ff <= ST_OPC;
                                    cnt_ff <= 6'd8;
                                end
                            end
                        end
                    end
                    ST_ADDR: begin
                        addrSh_ff <= addrNext;
                        cnt_ff <= cnt_ff + {3'd0, inBits};
                        if (cnt_ff + {3'd0, inBits} == AW_BITS) begin
                            // address lands at once so the array has the dummy time to answer
                            cnt_ff <= 6'd0;
                            memAddr <= addrNext;
                            state_ff <= useMode_ff ? ST_MODE : ST_DUMMY;
                        end
                    end
                    ST_MODE: begin
                        // mode byte on four lines, then the shorter dummy
                        modeSh_ff <= modeNext;
                        cnt_ff <= cnt_ff + 6'd1;
                        if (cnt_ff == 6'd`SFR_QUAD_MODE_CLKS - 6'd1) begin
                            cnt_ff <= 6'd0;
                            keepEnh_ff <= keepsEnh(modeNext);
                            if (keepsEnh(modeNext))
                                enhancedMode <= 1'b1;
                            dummyLen_ff <= 6'd`SFR_QUAD_ENH_DUMMY_CLKS;
                            state_ff <= ST_DUMMY;
                        end
                    end
                    ST_DUMMY: begin
                        // line contents ignored here
                        cnt_ff <= cnt_ff + 6'd1;
                        if (cnt_ff == dummyLen_ff - 6'd1) begin
                            cnt_ff <= 6'd0;
                            outSh_ff <= memData;
                            outBit_ff <= 4'd0;
                            state_ff <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        // rising edges carry nothing once data flows
                    end
                    ST_IGNORE: begin
                        // refused or unknown opcode: edges go unused until deselect
                    end
                    default: begin
                    end
                endcase
            end else if (sclkFall && state_ff == ST_DATA) begin
                // data changes on falling edges
                case (outW_ff)
                    W4: begin
                        dataLineOut <= outSh_ff[7:4];
                        dataLineOe <= 4'hF;
                    end
                    W2: begin
                        dataLineOut <= {2'b00, outSh_ff[7:6]};
                        dataLineOe <= 4'h3; // relies on host release of line 0
                    end
                    default: begin
                        dataLineOut <= {2'b00, outSh_ff[7], 1'b0};
                        dataLineOe <= 4'h2;
                    end
                endcase
                // lanes: single on line 1, dual on lines 1..0, quad on lines 3..0
                if (outBit_ff + {1'b0, outBits} == 4'd8) begin
                    // limitation: the array must answer within one clock of the address step
                    // next byte; natural overflow wraps to zero
                    memAddr <= memAddr + {{(AW-1){1'b0}}, 1'b1};
                    outBit_ff <= 4'd0;
                    state_ff <= ST_DATA;
                    outSh_ff <= 8'h00;
                    cnt_ff <= 6'd1;
                end else begin
                    outBit_ff <= outBit_ff + {1'b0, outBits};
                    outSh_ff <= outSh_ff << outBits;
                end
            end else if (cnt_ff == 6'd1 && state_ff == ST_DATA) begin
                // reload after memAddr settled
                // memData follows memAddr combinationally, but memAddr only moves at the step, hence the extra step
                outSh_ff <= memData;
                cnt_ff <= 6'd0;
            end
        end
    end
endmodule // sfr_read_front
`default_nettype wire

// ---- rtl/sfr_defines.vh ----
// sfr_defines.vh: opcodes, address width and phase lengths for the serial flash read front end
// assumes inclusion by the read front end only
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DUAL_OUT 8'h3B
`define SFR_OP_DUAL_IO 8'hBB
`define SFR_OP_QUAD_IO 8'hEB
`define SFR_OP_RESET_ENH 8'hFF
`define SFR_ADDR_BITS 24
`define SFR_FAST_DUMMY_CLKS 8
`define SFR_DUAL_OUT_DUMMY_CLKS 8
`define SFR_DUAL_IO_DUMMY_CLKS 4
`define SFR_QUAD_DUMMY_CLKS 6
`define SFR_QUAD_MODE_CLKS 2
`define SFR_QUAD_ENH_DUMMY_CLKS 4
`endif

// ---- verification/sfr_read_checker.sv ----
// sfr_read_checker.sv: port-level assertions for the serial flash read front end
// assumes bind onto sfr_read_front and a spi clock at most clock/8
`timescale 1ns/1ns
`default_nettype none
module sfr_read_checker #(
    parameter AW = 24 // address width
) (
    input wire clock, // system clock
    input wire rst, // sync reset
    input wire spiClk, // serial clock pin
    input wire chipSelN, // select, active low
    input wire writeBusy, // write cycle running
    input wire [AW-1:0] memAddr, // read address
    input wire [3:0] dataLineOut, // driven line values
    input wire [3:0] dataLineOe, // line enables
    input wire enhancedMode, // enhanced mode
    input wire pinFuncSuspend // protect and hold off
);
    reg [2:0] csHigh_ff;
    reg busyFrame_ff;
    always @(posedge clock) begin
        if (rst || !chipSelN)
            csHigh_ff <= 3'h0;
        else if (csHigh_ff != 3'h7)
            csHigh_ff <= csHigh_ff + 3'h1;
    end
    // busy is judged at frame start only; a cycle cannot begin mid-read
    always @(posedge clock) begin
        if (rst || chipSelN)
            busyFrame_ff <= 1'b0;
        else if (csHigh_ff != 3'h0)
            busyFrame_ff <= writeBusy;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_oe_release: assert property ($rose(chipSelN) |-> ##[1:6] dataLineOe == 4'h0)
        else $error("lines still driven after deselect");
    a_busy_quiet: assert property (busyFrame_ff |-> dataLineOe == 4'h0)
        else $error("read answered during write cycle");
    a_quad_suspend: assert property (dataLineOe == 4'hF |-> pinFuncSuspend)
        else $error("pin functions active in quad read");
    a_oe_lanes: assert property (dataLineOe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("illegal lane set driven");
    a_addr_step: assert property (dataLineOe != 4'h0 && $past(dataLineOe) != 4'h0
        && $changed(memAddr) |-> memAddr == $past(memAddr) + 1'b1)
        else $error("read address did not step by one");
    a_enh_set: assert property ($rose(enhancedMode) |-> !chipSelN)
        else $error("enhanced mode set outside a frame");
    a_enh_clear: assert property ($fell(enhancedMode) |-> csHigh_ff != 3'h0)
        else $error("enhanced mode cleared inside a frame");
    a_out_falling: assert property ($changed(dataLineOut) && dataLineOe != 4'h0 |-> !spiClk)
        else $error("data changed while serial clock high");
    cover property ($rose(enhancedMode));
    cover property (dataLineOe == 4'h3);
    cover property (busyFrame_ff && !chipSelN);
endmodule // sfr_read_checker
bind sfr_read_front sfr_read_checker #(.AW(AW)) sfr_read_checker_i (.clock(clock), .rst(rst),
    .spiClk(spiClk), .chipSelN(chipSelN), .writeBusy(writeBusy), .memAddr(memAddr),
    .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .enhancedMode(enhancedMode),
    .pinFuncSuspend(pinFuncSuspend));
`default_nettype wire

// ---- verification/sfr_spi_host.sv ----
// sfr_spi_host.sv: behavioural spi host, mode 0, clock still between frames
// assumes the bench resolves lines from both parties' enables
`timescale 1ns/1ns
`default_nettype none
module sfr_spi_host (
    output logic spiClk, // serial clock, idles low
    output logic chipSelN, // select, active low
    output logic [3:0] hostOut, // host line values
    output logic [3:0] hostOe, // host line enables
    input wire logic [3:0] lines // resolved line levels
);
    initial begin
        spiClk = 1'b0;
        chipSelN = 1'b1;
        hostOut = 4'h0;
        hostOe = 4'h0;
    end
    function automatic [3:0] laneMask(input int w);
        laneMask = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF;
    endfunction
    // offset keeps pin changes away from the system clock edge
    task automatic select();
        #5;
        chipSelN = 1'b0;
        #80;
    endtask
    // bits set with clock low, taken on the rising edge
    task automatic send(input [31:0] v, input int n, input int w);
        for (int i = n - 1; i >= 0; i--) begin
            spiClk = 1'b0;
            hostOe = laneMask(w);
            hostOut = 4'(v >> (i * w)) & laneMask(w);
            #80;
            spiClk = 1'b1;
            #80;
        end
    endtask
    // lines released before the first data falling edge
    task automatic recv(input int n, input int w, output [31:0] v);
        v = 0;
        hostOe = 4'h0;
        for (int i = 0; i < n; i++) begin
            spiClk = 1'b0;
            #80;
            v = (v << w) | ((w == 1) ? {3'h0, lines[1]} : lines & laneMask(w));
            spiClk = 1'b1;
            #80;
        end
    endtask
    task automatic deselect();
        #80;
        spiClk = 1'b0;
        hostOe = 4'h0;
        #40;
        chipSelN = 1'b1;
        #200;
    endtask
endmodule // sfr_spi_host
`default_nettype wire

// ---- verification/sfr_read_front_tb_top.sv ----
// sfr_read_front_tb_top.sv: self-checking bench for the read front end
// assumes the host model drives the pins; memory is a fixed address pattern
`timescale 1ns/1ns
`default_nettype none
module sfr_read_front_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic writeBusy = 1'b0;
    logic quadPeripheralMode = 1'b0;
    wire logic spiClk, chipSelN;
    wire logic [3:0] hostOut, hostOe, lineLvl, dataLineOut, dataLineOe;
    wire logic [23:0] memAddr;
    wire logic [7:0] memData;
    wire logic enhancedMode, pinFuncSuspend;
    int badCount = 0;
    int comparisons = 0;
    always #10 clock = ~clock;
    function automatic [7:0] mem(input [23:0] a);
        mem = a[7:0] + {a[15:12], a[19:16]} + 8'h5A;
    endfunction
    assign memData = memAddr[7:0] + {memAddr[15:12], memAddr[19:16]} + 8'h5A;
    // released line shows the inverse of the host's last value
    assign lineLvl = (hostOe & hostOut) | (~hostOe & dataLineOe & dataLineOut)
        | (~hostOe & ~dataLineOe & ~hostOut);
    sfr_spi_host sfr_spi_host_i (.spiClk(spiClk), .chipSelN(chipSelN), .hostOut(hostOut),
        .hostOe(hostOe), .lines(lineLvl));
    sfr_read_front #(.AW(24)) sfr_read_front_i (.clock(clock), .rst(rst), .spiClk(spiClk),
        .chipSelN(chipSelN), .dataLineIn(lineLvl), .writeBusy(writeBusy),
        .quadPeripheralMode(quadPeripheralMode), .memData(memData), .memAddr(memAddr),
        .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .enhancedMode(enhancedMode),
        .pinFuncSuspend(pinFuncSuspend));
    task automatic check(input [31:0] seen, input [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // opW 0 skips the opcode; dummy clocks use the address lane width
    task automatic frame(input [7:0] op, input int opW, input int aw, input [7:0] md,
        input int mc, input int dum, input int dw, input int nb, input [23:0] a, input busy);
        logic [31:0] v;
        @(posedge clock);
        writeBusy <= busy;
        sfr_spi_host_i.select();
        if (opW != 0)
            sfr_spi_host_i.send(op, 8 / opW, opW);
        sfr_spi_host_i.send(a, 24 / aw, aw);
        if (mc != 0)
            sfr_spi_host_i.send(md, mc, 4);
        sfr_spi_host_i.send(32'hA5A5_A5A5, dum, aw);
        for (int i = 0; i < nb; i++) begin
            sfr_spi_host_i.recv(8 / dw, dw, v);
            if (!busy)
                check(v, mem(a + 24'(i)));
        end
        check(dataLineOe, busy ? 4'h0 : (dw == 1) ? 4'h2 : (dw == 2) ? 4'h3 : 4'hF);
        if (dw == 4 && !busy)
            check(pinFuncSuspend, 1'b1);
        sfr_spi_host_i.deselect();
        check(dataLineOe, 4'h0);
        @(posedge clock);
        writeBusy <= 1'b0;
    endtask
    task automatic fastWrap();
        frame(8'h0B, 1, 1, 8'h00, 0, 8, 1, 3, 24'hFF_FFFE, 1'b0);
    endtask
    task automatic dualReads();
        frame(8'h3B, 1, 1, 8'h00, 0, 8, 2, 2, 24'h01_2345, 1'b0);
        frame(8'hBB, 1, 2, 8'h00, 0, 4, 2, 2, 24'hFF_ABCF, 1'b0);
    endtask
    task automatic quadEnhanced();
        frame(8'hEB, 1, 4, 8'hA5, 2, 4, 4, 2, 24'h34_5678, 1'b0);
        check(enhancedMode, 1'b1);
        frame(8'h00, 0, 4, 8'h00, 2, 4, 4, 2, 24'h00_F0FF, 1'b0);
        check(enhancedMode, 1'b0);
    endtask
    task automatic ffExit();
        frame(8'hEB, 1, 4, 8'h5A, 2, 4, 4, 1, 24'h12_0000, 1'b0);
        check(enhancedMode, 1'b1);
        sfr_spi_host_i.select();
        sfr_spi_host_i.send(32'hFFFF_FFFF, 8, 4);
        sfr_spi_host_i.deselect();
        check(enhancedMode, 1'b0);
    endtask
    task automatic qpiFast();
        @(posedge clock);
        quadPeripheralMode <= 1'b1;
        frame(8'h0B, 4, 4, 8'h00, 0, 6, 4, 2, 24'h00_1234, 1'b0);
        quadPeripheralMode <= 1'b0;
    endtask
    task automatic busyReject();
        frame(8'h0B, 1, 1, 8'h00, 0, 8, 1, 1, 24'h00_0010, 1'b1);
        frame(8'hEB, 1, 4, 8'hF0, 2, 4, 4, 1, 24'h00_0020, 1'b1);
        check(enhancedMode, 1'b0);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        fastWrap();
        dualReads();
        quadEnhanced();
        ffExit();
        qpiFast();
        busyReject();
        results();
    end
    // all frames together take well under this span
    initial begin
        #600000;
        badCount++;
        results();
    end
endmodule // sfr_read_front_tb_top
`default_nettype wire
